// ---- common/tcpwm_pkg.sv ----
// Overview of operation
// - All three generators run only while the clock register enable bit 7 is set.
// - The source clock is divided by 2 to the power of the 3-bit prescaler code.
// - Source select 0 takes the system clock, 1 the fast internal oscillator or twice it.
// - The shared bound takes bits 10:3 from its high byte and bits 2:1 from low bits 7:6.
// - Each duty is 11 bits: high register bits 10:3, low register bits 7:5 give bits 2:0.
// - Control bit 5 inverts the channel generator output.
// - Control bit 6 reads back the current generator output level.
// - Channel zero bit 4 selects its own wave or zero xor/or one, chosen by bit 0.
// - Channel zero port codes 001, 011 and 100 route to port b 5, port a 0 and port b 4.
// - Channel one bit 4 selects its own wave or channel two's wave.
// - Channel one port codes 001, 011 and 100 route to port b 6, port a 4 and port b 7.
// - Channel two bit 4 selects its wave directly or divided by two.
// - Channel two codes 001, 011, 100 and 101 go to port b 3, port a 3, port b 2, port a 5.
package tcpwm_pkg;
    localparam int TCPWM_DW = 11;
    localparam logic [5:0] TCPWM_A_C0 = 6'h20;
    localparam logic [5:0] TCPWM_A_CLK = 6'h21;
    localparam logic [5:0] TCPWM_A_D0H = 6'h22;
    localparam logic [5:0] TCPWM_A_D0L = 6'h23;
    localparam logic [5:0] TCPWM_A_BH = 6'h24;
    localparam logic [5:0] TCPWM_A_BL = 6'h25;
    localparam logic [5:0] TCPWM_A_C1 = 6'h26;
    localparam logic [5:0] TCPWM_A_D1H = 6'h28;
    localparam logic [5:0] TCPWM_A_D1L = 6'h29;
    localparam logic [5:0] TCPWM_A_C2 = 6'h2c;
    localparam logic [5:0] TCPWM_A_D2H = 6'h2e;
    localparam logic [5:0] TCPWM_A_D2L = 6'h2f;
    localparam int TCPWM_B_EN = 7;
    localparam int TCPWM_B_PSC = 4;
    localparam int TCPWM_B_SRC = 0;
    localparam int TCPWM_B_STAT = 6;
    localparam int TCPWM_B_INV = 5;
    localparam int TCPWM_B_SEL = 4;
    localparam int TCPWM_B_PORT = 1;
    localparam int TCPWM_B_COMB = 0;
    localparam logic [7:0] TCPWM_CLK_RST = 8'h00;
    localparam logic [7:0] TCPWM_CTL_RST = 8'h00;
    localparam logic [2:0] TCPWM_P_OFF = 3'h0;
    localparam logic [2:0] TCPWM_P_1 = 3'h1;
    localparam logic [2:0] TCPWM_P_3 = 3'h3;
    localparam logic [2:0] TCPWM_P_4 = 3'h4;
    localparam logic [2:0] TCPWM_P_5 = 3'h5;
endpackage

// ---- common/tcpwm_tick_if.sv ----
`timescale 1ns/1ps
interface tcpwm_tick_if;
    logic tick;
    logic [10:0] count;
    modport src (output tick, output count);
    modport dst (input tick, input count);
endinterface

// ---- core/tcpwm_timebase.sv ----
`timescale 1ns/1ps
module tcpwm_timebase (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // source clock pulses
    input wire logic sys_tick,
    input wire logic fast_tick,
    // settings
    input wire logic run,
    input wire logic src_sel,
    input wire logic [2:0] psc,
    input wire logic [10:0] bound,
    // to channels
    tcpwm_tick_if.src tb
);
    import tcpwm_pkg::*;
    typedef struct packed {
        logic [6:0] div;
        logic [10:0] cnt;
        logic tick;
    } tcpwm_tb_t;
    tcpwm_tb_t st_ff, nxt_st;
    logic src_pulse;
    logic div_hit;
    always_comb begin
        src_pulse = src_sel ? fast_tick : sys_tick;
        div_hit = ((st_ff.div & ((7'h01 << psc) - 7'h01)) == ((7'h01 << psc) - 7'h01));
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        if (!run) begin
            nxt_st.div = 7'h00;
            nxt_st.cnt = 11'h000;
        end else if (src_pulse) begin
            nxt_st.div = st_ff.div + 7'h01;
            if (div_hit) begin
                nxt_st.div = 7'h00;
                nxt_st.tick = 1'b1;
                // count up to bound then wrap
                nxt_st.cnt = (st_ff.cnt >= bound) ? 11'h000 : st_ff.cnt + 11'h001;
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
    assign tb.tick = st_ff.tick;
    assign tb.count = st_ff.cnt;

    property p_wrap;
        @(posedge ref_clk) disable iff (sys_rst)
        (run && src_pulse && div_hit && st_ff.cnt >= bound) |=> (st_ff.cnt == 11'h000);
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not wrap");
    property p_idle;
        @(posedge ref_clk) disable iff (sys_rst)
        !run |=> (st_ff.cnt == 11'h000 && !st_ff.tick);
    endproperty
    a_idle: assert property (p_idle) else $error("counter ran while disabled");
    property p_div1;
        @(posedge ref_clk) disable iff (sys_rst)
        (run && src_pulse && psc == 3'h0) |=> st_ff.tick;
    endproperty
    a_div1: assert property (p_div1) else $error("divide by one missed a tick");
endmodule

// ---- core/tcpwm_top.sv ----
`timescale 1ns/1ps
module tcpwm_top #(
    parameter bit FAST_DOUBLE = 1'b0
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // oscillator pulses, one cycle each
    input wire logic fast_internal_oscillator,
    input wire logic fast_internal_oscillator_x2,
    // i/o register port
    input wire logic [5:0] io_addr,
    input wire logic io_wr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    // port lines
    output logic port_b_line_5,
    output logic port_a_line_0,
    output logic port_b_line_4,
    output logic port_b_line_6,
    output logic port_a_line_4,
    output logic port_b_line_7,
    output logic port_b_line_3,
    output logic port_a_line_3,
    output logic port_b_line_2,
    output logic port_a_line_5,
    // per-line drive enable from this block
    output logic [9:0] port_oe
);
    import tcpwm_pkg::*;
    typedef struct packed {
        logic [7:0] clk_cfg;
        logic [7:0] bnd_hi;
        logic [1:0] bnd_lo;
        logic [2:0][5:0] ctl;
        logic [2:0][2:0] duty_lo;
        logic [2:0][TCPWM_DW-1:0] duty;
        logic [2:0] wave;
        logic half;
        logic [9:0] pins;
        logic [9:0] oe;
        logic [7:0] rd;
    } tcpwm_st_t;
    tcpwm_st_t st_ff, nxt_st;
    tcpwm_tick_if tb ();
    logic [10:0] bound;
    logic run;
    logic [2:0] gen;
    logic [2:0] sel;
    logic [2:0][2:0] port;
    logic [5:0] caddr [3];
    logic [5:0] haddr [3];
    logic [5:0] laddr [3];

    assign bound = {st_ff.bnd_hi, st_ff.bnd_lo, 1'b0};
    assign run = st_ff.clk_cfg[TCPWM_B_EN];
    assign caddr = '{TCPWM_A_C0, TCPWM_A_C1, TCPWM_A_C2};
    assign haddr = '{TCPWM_A_D0H, TCPWM_A_D1H, TCPWM_A_D2H};
    assign laddr = '{TCPWM_A_D0L, TCPWM_A_D1L, TCPWM_A_D2L};

    tcpwm_timebase u_tb (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .sys_tick(1'b1),
        .fast_tick(FAST_DOUBLE ? fast_internal_oscillator_x2 : fast_internal_oscillator),
        .run(run),
        .src_sel(st_ff.clk_cfg[TCPWM_B_SRC]),
        .psc(st_ff.clk_cfg[TCPWM_B_PSC +: 3]),
        .bound(bound),
        .tb(tb.src)
    );

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            gen[i] = st_ff.wave[i] ^ st_ff.ctl[i][TCPWM_B_INV];
            port[i] = st_ff.ctl[i][TCPWM_B_PORT +: 3];
        end
        if (!st_ff.ctl[0][TCPWM_B_SEL]) begin
            sel[0] = gen[0];
        end else if (st_ff.ctl[0][TCPWM_B_COMB]) begin
            sel[0] = gen[0] | gen[1];
        end else begin
            sel[0] = gen[0] ^ gen[1];
        end
        // channel one may carry channel two
        sel[1] = st_ff.ctl[1][TCPWM_B_SEL] ? gen[2] : gen[1];
        sel[2] = st_ff.ctl[2][TCPWM_B_SEL] ? st_ff.half : gen[2];
    end

    always_comb begin
        nxt_st = st_ff;
        if (io_wr) begin
            if (io_addr == TCPWM_A_CLK) begin
                nxt_st.clk_cfg = io_wdata & 8'hf1;
            end
            if (io_addr == TCPWM_A_BH) begin
                nxt_st.bnd_hi = io_wdata;
            end
            if (io_addr == TCPWM_A_BL) begin
                nxt_st.bnd_lo = io_wdata[7:6];
            end
            for (int i = 0; i < 3; i++) begin
                if (io_addr == caddr[i]) begin
                    nxt_st.ctl[i] = io_wdata[5:0];
                end
                // low bits kept until high write
                if (io_addr == laddr[i]) begin
                    nxt_st.duty_lo[i] = io_wdata[7:5];
                end
                if (io_addr == haddr[i]) begin
                    nxt_st.duty[i] = {io_wdata, st_ff.duty_lo[i]};
                end
            end
        end
        for (int i = 0; i < 3; i++) begin
            nxt_st.wave[i] = run && (tb.count < st_ff.duty[i]);
        end
        if (!run) begin
            nxt_st.half = 1'b0;
        end else if (st_ff.wave[2] == 1'b0 && nxt_st.wave[2] == 1'b1) begin
            nxt_st.half = ~st_ff.half;
        end
        nxt_st.oe = 10'h000;
        case (port[0])
            TCPWM_P_1: nxt_st.oe[0] = 1'b1;
            TCPWM_P_3: nxt_st.oe[1] = 1'b1;
            TCPWM_P_4: nxt_st.oe[2] = 1'b1;
            default: ;
        endcase
        case (port[1])
            TCPWM_P_1: nxt_st.oe[3] = 1'b1;
            TCPWM_P_3: nxt_st.oe[4] = 1'b1;
            TCPWM_P_4: nxt_st.oe[5] = 1'b1;
            default: ;
        endcase
        case (port[2])
            TCPWM_P_1: nxt_st.oe[6] = 1'b1;
            TCPWM_P_3: nxt_st.oe[7] = 1'b1;
            TCPWM_P_4: nxt_st.oe[8] = 1'b1;
            TCPWM_P_5: nxt_st.oe[9] = 1'b1;
            default: ;
        endcase
        nxt_st.pins = nxt_st.oe & {{4{sel[2]}}, {3{sel[1]}}, {3{sel[0]}}};
        nxt_st.rd = 8'h00;
        for (int i = 0; i < 3; i++) begin
            if (io_addr == caddr[i]) begin
                nxt_st.rd = {1'b0, gen[i], st_ff.ctl[i]};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign io_rdata = st_ff.rd;
    assign port_oe = st_ff.oe;
    assign {port_a_line_5, port_b_line_2, port_a_line_3, port_b_line_3, port_b_line_7,
            port_a_line_4, port_b_line_6, port_b_line_4, port_a_line_0, port_b_line_5} =
           st_ff.pins;

    property p_duty_apply;
        @(posedge ref_clk) disable iff (sys_rst)
        (io_wr && io_addr == TCPWM_A_D0H) |=>
            (st_ff.duty[0] == {$past(io_wdata), $past(st_ff.duty_lo[0])});
    endproperty
    a_duty_apply: assert property (p_duty_apply) else $error("duty high write not applied");
    property p_low_only;
        @(posedge ref_clk) disable iff (sys_rst)
        (io_wr && io_addr == TCPWM_A_D1L) |=> $stable(st_ff.duty[1]);
    endproperty
    a_low_only: assert property (p_low_only) else $error("low write changed duty");
    property p_off;
        @(posedge ref_clk) disable iff (sys_rst)
        (port[2] == TCPWM_P_OFF) |=> (st_ff.pins[9:6] == 4'h0);
    endproperty
    a_off: assert property (p_off) else $error("disabled channel drove a pin");
    property p_route0;
        @(posedge ref_clk) disable iff (sys_rst)
        (port[0] == TCPWM_P_3) |=> (st_ff.oe[1] && port_a_line_0 == $past(sel[0]));
    endproperty
    a_route0: assert property (p_route0) else $error("channel zero misrouted");
    property p_route1;
        @(posedge ref_clk) disable iff (sys_rst)
        (port[1] == TCPWM_P_4) |=> (st_ff.oe[5] && port_b_line_7 == $past(sel[1]));
    endproperty
    a_route1: assert property (p_route1) else $error("channel one misrouted");
    property p_or;
        @(posedge ref_clk) disable iff (sys_rst)
        (st_ff.ctl[0][TCPWM_B_SEL] && st_ff.ctl[0][TCPWM_B_COMB] && port[0] == TCPWM_P_1)
            |=> (port_b_line_5 == ($past(gen[0]) | $past(gen[1])));
    endproperty
    a_or: assert property (p_or) else $error("or combine wrong");
    property p_swap;
        @(posedge ref_clk) disable iff (sys_rst)
        (st_ff.ctl[1][TCPWM_B_SEL] && port[1] == TCPWM_P_1) |=>
            (port_b_line_6 == $past(st_ff.wave[2] ^ st_ff.ctl[2][TCPWM_B_INV]));
    endproperty
    a_swap: assert property (p_swap) else $error("channel one not carrying two");
    property p_stat;
        @(posedge ref_clk) disable iff (sys_rst)
        (io_addr == TCPWM_A_C2) |=> (io_rdata[TCPWM_B_STAT] == $past(gen[2]));
    endproperty
    a_stat: assert property (p_stat) else $error("status bit wrong");
    property p_inv;
        @(posedge ref_clk) disable iff (sys_rst)
        (st_ff.ctl[0][TCPWM_B_INV] && !st_ff.ctl[0][TCPWM_B_SEL] && port[0] == TCPWM_P_1) |=>
            (port_b_line_5 == !$past(st_ff.wave[0]));
    endproperty
    a_inv: assert property (p_inv) else $error("inversion missing");
    property p_wave;
        @(posedge ref_clk) disable iff (sys_rst)
        (run && tb.count < st_ff.duty[2]) |=> st_ff.wave[2];
    endproperty
    a_wave: assert property (p_wave) else $error("wave low below duty");
    // count only moves on a prescaled tick while running
    property p_step;
        @(posedge ref_clk) disable iff (sys_rst)
        (run && $past(run) && tb.count != $past(tb.count)) |-> tb.tick;
    endproperty
    a_step: assert property (p_step) else $error("count moved without a tick");
endmodule

// ---- tb/tcpwm_osc_model.sv ----
`timescale 1ns/1ps
module tcpwm_osc_model #(
    parameter int P = 4
) (
    input wire logic ref_clk,
    output logic fast_internal_oscillator,
    output logic fast_internal_oscillator_x2
);
    int ph = 0;
    initial begin
        fast_internal_oscillator = 1'b0;
        fast_internal_oscillator_x2 = 1'b0;
    end
    always @(negedge ref_clk) begin
        ph <= (ph + 1) % P;
        fast_internal_oscillator <= (ph == 0);
        fast_internal_oscillator_x2 <= (ph % (P / 2) == 0);
    end
endmodule

// ---- tb/tcpwm_top_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tcpwm_top_tb_top;
    import tcpwm_pkg::*;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic osc, osc2, io_wr = 1'b0;
    logic [5:0] io_addr = 6'h00;
    logic [7:0] io_wdata = 8'h00;
    logic [7:0] io_rdata;
    logic [9:0] pins, port_oe;
    int miscompares = 0, n_tests = 0, stat, cnt[10], rise[10], unk = 0;
    logic [5:0] ca[3] = '{TCPWM_A_C0, TCPWM_A_C1, TCPWM_A_C2};
    tcpwm_osc_model #(.P(4)) i_tcpwm_osc_model (.ref_clk(ref_clk),
        .fast_internal_oscillator(osc), .fast_internal_oscillator_x2(osc2));
    tcpwm_top #(.FAST_DOUBLE(1'b0)) i_tcpwm_top (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .fast_internal_oscillator(osc), .fast_internal_oscillator_x2(osc2),
        .io_addr(io_addr), .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .port_b_line_5(pins[0]), .port_a_line_0(pins[1]), .port_b_line_4(pins[2]),
        .port_b_line_6(pins[3]), .port_a_line_4(pins[4]), .port_b_line_7(pins[5]),
        .port_b_line_3(pins[6]), .port_a_line_3(pins[7]), .port_b_line_2(pins[8]),
        .port_a_line_5(pins[9]), .port_oe(port_oe));
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge ref_clk);
        io_wr = 1'b0;
    endtask
    task automatic duty(input int ch, input logic [10:0] v);
        wr(ca[ch] + 6'h3, {v[2:0], 5'h00});
        wr(ca[ch] + 6'h2, v[10:3]);
    endtask
    // settle a full window first, so prescaler phase steps are gone
    task automatic meas(input int n, input logic [5:0] a);
        logic [9:0] prev;
        io_addr = a;
        repeat (n + 20) @(negedge ref_clk);
        prev = pins;
        stat = 0;
        for (int i = 0; i < 10; i++) begin
            cnt[i] = 0;
            rise[i] = 0;
        end
        repeat (n) begin
            @(negedge ref_clk);
            stat += (io_rdata[6] === 1'b1);
            unk += $isunknown({pins, port_oe, io_rdata});
            for (int i = 0; i < 10; i++) begin
                cnt[i] += (pins[i] === 1'b1);
                rise[i] += (pins[i] === 1'b1 && prev[i] === 1'b0);
            end
            prev = pins;
        end
    endtask
    function automatic int lidx(input int ch, input int code);
        if (code == 1) return ch * 3;
        if (code == 3) return ch * 3 + 1;
        if (code == 4) return ch * 3 + 2;
        if (code == 5 && ch == 2) return 9;
        return -1;
    endfunction
    task automatic t_reset;
        meas(4, TCPWM_A_C0);
        `CHK(io_rdata, 8'h00)
        `CHK({pins, port_oe}, 20'h00000)
    endtask
    task automatic t_base;
        wr(TCPWM_A_CLK, 8'h80);
        wr(TCPWM_A_BH, 8'h01);
        wr(TCPWM_A_BL, 8'h00);
        duty(0, 11'd3);
        wr(TCPWM_A_C0, 8'h02);
        meas(36, TCPWM_A_C0);
        `CHK(cnt[0], 12)
        `CHK(rise[0], 4)
        `CHK(port_oe, 10'h001)
        wr(TCPWM_A_D0L, 8'hc0);
        meas(36, TCPWM_A_C0);
        `CHK(cnt[0], 12)
        wr(TCPWM_A_D0H, 8'h00);
        meas(36, TCPWM_A_C0);
        `CHK(cnt[0], 24)
        wr(TCPWM_A_BH, 8'h00);
        wr(TCPWM_A_BL, 8'hc0);
        meas(28, TCPWM_A_C0);
        `CHK(cnt[0], 24)
        `CHK(rise[0], 4)
        wr(TCPWM_A_BH, 8'h01);
        wr(TCPWM_A_BL, 8'h00);
    endtask
    task automatic t_route;
        int li;
        for (int ch = 0; ch < 3; ch++) duty(ch, 11'd3);
        wr(TCPWM_A_C0, 8'h00);
        for (int ch = 0; ch < 3; ch++) begin
            for (int c = 0; c < 8; c++) begin
                wr(ca[ch], 8'(c << 1));
                meas(36, ca[ch]);
                li = lidx(ch, c);
                for (int i = 0; i < 10; i++) `CHK(cnt[i], (i == li) ? 12 : 0)
                `CHK(port_oe, (li < 0) ? 10'h000 : 10'(10'h001 << li))
            end
            wr(ca[ch], 8'h00);
        end
    endtask
    task automatic t_inv;
        wr(TCPWM_A_C0, 8'h22);
        meas(36, TCPWM_A_C0);
        `CHK(cnt[0], 24)
        `CHK(stat, 24)
        wr(TCPWM_A_C0, 8'h02);
    endtask
    task automatic t_psc;
        for (int k = 0; k < 8; k++) begin
            wr(TCPWM_A_CLK, 8'(8'h80 | (k << 4)));
            meas(18 << k, TCPWM_A_C0);
            `CHK(cnt[0], 6 << k)
            `CHK(rise[0], 2)
        end
    endtask
    task automatic t_src;
        wr(TCPWM_A_CLK, 8'h81);
        meas(72, TCPWM_A_C0);
        `CHK(rise[0], 2)
        `CHK(cnt[0], 24)
        wr(TCPWM_A_CLK, 8'h80);
    endtask
    task automatic t_comb;
        duty(1, 11'd6);
        duty(2, 11'd5);
        wr(TCPWM_A_C0, 8'h12);
        meas(36, TCPWM_A_C0);
        `CHK(cnt[0], 12)
        wr(TCPWM_A_C0, 8'h13);
        wr(TCPWM_A_C1, 8'h12);
        wr(TCPWM_A_C2, 8'h12);
        meas(72, TCPWM_A_C2);
        `CHK(cnt[0], 48)
        `CHK(cnt[3], 40)
        `CHK(cnt[6], 36)
        `CHK(rise[6], 4)
    endtask
    task automatic t_off;
        wr(TCPWM_A_CLK, 8'h00);
        meas(36, TCPWM_A_C0);
        `CHK(cnt[0] + cnt[3] + cnt[6] + stat, 0)
    endtask
    // reset after t_off has stopped the clock clears the routing left by earlier scenarios
    task automatic t_rst2;
        @(negedge ref_clk);
        sys_rst = 1'b1;
        repeat (5) @(negedge ref_clk);
        sys_rst = 1'b0;
        meas(36, TCPWM_A_C0);
        `CHK({io_rdata, port_oe, pins}, 28'h0000000)
        `CHK(unk, 0)
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge ref_clk);
        @(negedge ref_clk);
        sys_rst = 1'b0;
        t_reset();
        t_base();
        t_route();
        t_inv();
        t_psc();
        t_src();
        t_comb();
        t_off();
        t_rst2();
        tally_and_finish();
    end
    initial begin
        #500us;
        miscompares++;
        tally_and_finish();
    end
endmodule
